// ---- hw/pc_seq_pkg.sv ----
package pc_seq_pkg;
	localparam int PC_W = 12;
	localparam int DATA_W = 8;
	localparam int INSTR_W = 16;
	localparam int STACK_DEPTH = 8;
	localparam int STACK_AW = 3;
	localparam int PHASE_COUNT = 4;
	localparam logic [PC_W-1:0] RESET_PC = 12'h000;
	localparam logic [PC_W-1:0] IRQ_VECTOR = 12'h004;
	localparam logic [3:0] STACK_EMPTY_DEPTH = 4'h0;
	localparam logic [3:0] STACK_FULL_DEPTH = 4'h8;
	localparam logic [1:0] PHASE_T1 = 2'h0;
	localparam logic [1:0] PHASE_T4 = 2'h3;

	localparam logic [7:0] OFF_PC_LOW = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h04;
	localparam logic [7:0] OFF_STATE = 8'h08;
	localparam logic [7:0] OFF_ACC = 8'h0C;
	localparam int CTRL_RUN_BIT = 0;
	localparam logic CTRL_RUN_RESET = 1'b1;
	localparam int STATE_FLAGS_POS = 16;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [3:0] FLAGS_RESET = 4'h0;

	localparam int FLAG_C = 0;
	localparam int FLAG_AC = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OV = 3;

	localparam logic [3:0] OP_NOP = 4'h0;
	localparam logic [3:0] OP_ALU = 4'h1;
	localparam logic [3:0] OP_ALU_EXT = 4'h2;
	localparam logic [3:0] OP_BRANCH = 4'h3;
	localparam logic [3:0] OP_CALL = 4'h4;
	localparam logic [3:0] OP_SUB_RETURN = 4'h5;
	localparam logic [3:0] OP_INT_RETURN = 4'h6;
	localparam logic [3:0] OP_SKIP = 4'h7;
	localparam logic [3:0] OP_WRITE_PC_LOW = 4'h8;
	localparam logic [INSTR_W-1:0] DUMMY_INSTR = 16'h0000;

	localparam logic [1:0] SKIP_ZERO = 2'h0;
	localparam logic [1:0] SKIP_NOT_ZERO = 2'h1;
	localparam logic [1:0] SKIP_INC_ZERO = 2'h2;
	localparam logic [1:0] SKIP_DEC_ZERO = 2'h3;

	typedef enum logic [3:0] {
		ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA, ALU_AND, ALU_OR, ALU_XOR,
		ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC, ALU_DEC, ALU_MOV
	} alu_op_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;
endpackage

// ---- hw/return_stack_ram.sv ----
`timescale 1ns/10ps
`default_nettype none
module return_stack_ram
	import pc_seq_pkg::*;
(
	input wire logic clock_i,
	input wire logic wr_en_i,
	input wire logic [STACK_AW-1:0] wr_addr_i,
	input wire logic [PC_W-1:0] wr_data_i,
	input wire logic [STACK_AW-1:0] rd_addr_i,
	output logic [PC_W-1:0] rd_data_o
);
	logic [PC_W-1:0] mem [STACK_DEPTH];

	always_ff @(posedge clock_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem[rd_addr_i];
	end
endmodule
`default_nettype wire

// ---- hw/cpu_fetch_pc_stack.sv ----
// Overview of operation
// [RQ1] Four phases form one instruction cycle
// [RQ2] Counter advances at phase one fetch
// [RQ3] Fetch overlaps previous instruction execution
// [RQ4] Extended instructions take two cycles
// [RQ5] Branches cost one extra cycle
// [RQ6] Counter increments by one otherwise
// [RQ7] Twelve bit counter, low byte addressable
// [RQ8] Branch, call, interrupt, reset load counter
// [RQ9] Met skip discards prefetch, dummy cycle
// [RQ10] Counter low byte readable and writable
// [RQ11] Low byte write jumps within page
// [RQ12] Eight hidden return stack entries
// [RQ13] Call and interrupt acknowledge push counter
// [RQ14] Returns pop stack into counter
// [RQ15] Reset points stack at top
// [RQ16] Full stack withholds interrupt acknowledge
// [RQ17] Call on full stack drops oldest
// [RQ18] Eight bit operands, result to accumulator
// [RQ19] Operations update status flags
// [RQ20] Full arithmetic, logic, rotate, skip set
// [RQ21] Reset starts execution at zero
`timescale 1ns/10ps
`default_nettype none
module cpu_fetch_pc_stack
	import pc_seq_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire apb_req_t apb_i,
	output apb_rsp_t apb_o,
	input wire logic [INSTR_W-1:0] prog_data_i,
	output logic [PC_W-1:0] prog_addr_o,
	output logic prog_rd_o,
	input wire logic irq_i,
	output logic irq_ack_o,
	output logic [PHASE_COUNT-1:0] instruction_phase_clocks_o
);
	logic [1:0] phase;
	logic run;
	logic [PC_W-1:0] pc;
	logic [INSTR_W-1:0] ir;
	logic ext_second;
	logic [DATA_W-1:0] acc;
	logic [3:0] flags;
	logic [STACK_AW-1:0] sp;
	logic [3:0] depth;
	logic [PC_W-1:0] stack_top;
	logic pc_low_req;
	logic [DATA_W-1:0] pc_low_data;
	logic t1_fire;
	logic t4_fire;
	logic stack_full;
	logic [PC_W-1:0] next_pc;
	logic load_pc;
	logic flush;
	logic push;
	logic pop;
	logic take_irq;
	logic pc_low_taken;
	logic ext_hold;
	logic alu_en;
	alu_op_t alu_op;
	logic [DATA_W-1:0] operand;
	logic [DATA_W-1:0] next_acc;
	logic [3:0] next_flags;
	logic [PC_W-1:0] return_addr;
	logic [3:0] op_class;
	logic apb_write;
	logic apb_setup;

	assign op_class = ir[15:12];
	assign stack_full = (depth == STACK_FULL_DEPTH);
	// The fetched word belongs to pc - 1, so that is where execution resumes
	assign return_addr = pc - 12'h001;
	assign t1_fire = run && (phase == PHASE_T1);
	assign t4_fire = run && (phase == PHASE_T4);
	assign apb_setup = apb_i.psel && !apb_i.penable;
	assign apb_write = apb_i.psel && apb_i.penable && apb_o.pready && apb_i.pwrite;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase <= PHASE_T1;
			instruction_phase_clocks_o <= 4'h0;
		end else if (run) begin
			phase <= phase + 2'h1; // see [RQ1]
			instruction_phase_clocks_o <= 4'h1 << phase;
		end else begin
			instruction_phase_clocks_o <= 4'h0;
		end
	end

	always_comb begin
		next_pc = pc;
		load_pc = 1'b0;
		flush = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		take_irq = 1'b0;
		pc_low_taken = 1'b0;
		ext_hold = 1'b0;
		alu_en = 1'b0;
		alu_op = alu_op_t'(ir[11:8]);
		operand = ir[7:0];
		case (op_class)
			OP_ALU: begin
				alu_en = 1'b1;
			end
			OP_ALU_EXT: begin
				if (ext_second) begin
					alu_en = 1'b1; // see [RQ4]
				end else begin
					ext_hold = 1'b1;
					load_pc = 1'b1;
					next_pc = return_addr;
				end
			end
			OP_BRANCH: begin
				load_pc = 1'b1; // see [RQ5] [RQ8]
				flush = 1'b1;
				next_pc = ir[PC_W-1:0];
			end
			OP_CALL: begin
				load_pc = 1'b1;
				flush = 1'b1;
				push = 1'b1; // see [RQ13] [RQ17]
				next_pc = ir[PC_W-1:0];
			end
			OP_SUB_RETURN, OP_INT_RETURN: begin
				load_pc = 1'b1;
				flush = 1'b1;
				pop = 1'b1; // see [RQ14]
				next_pc = stack_top;
			end
			OP_SKIP: begin
				case (ir[9:8])
					SKIP_ZERO: flush = (acc == 8'h00);
					SKIP_NOT_ZERO: flush = (acc != 8'h00);
					SKIP_INC_ZERO: begin
						alu_en = 1'b1;
						alu_op = ALU_INC;
						flush = (acc == 8'hFF);
					end
					default: begin
						alu_en = 1'b1;
						alu_op = ALU_DEC;
						flush = (acc == 8'h01);
					end
				endcase
			end
			OP_WRITE_PC_LOW: begin
				load_pc = 1'b1;
				flush = 1'b1;
				next_pc = {pc[PC_W-1:DATA_W], acc}; // see [RQ11]
			end
			default: begin
			end
		endcase
		// Interrupts only enter at a plain instruction boundary
		if (!load_pc && !flush && irq_i && !stack_full) begin
			take_irq = 1'b1; // see [RQ16]
			push = 1'b1;
			load_pc = 1'b1;
			flush = 1'b1;
			next_pc = IRQ_VECTOR;
		end else if (!load_pc && !flush && pc_low_req) begin
			pc_low_taken = 1'b1;
			load_pc = 1'b1;
			flush = 1'b1;
			next_pc = {pc[PC_W-1:DATA_W], pc_low_data}; // see [RQ11]
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pc <= RESET_PC; // see [RQ21] [RQ8]
			prog_addr_o <= RESET_PC;
			prog_rd_o <= 1'b0;
		end else begin
			prog_rd_o <= t1_fire;
			if (t1_fire) begin
				prog_addr_o <= pc;
				pc <= pc + 12'h001; // see [RQ2] [RQ6]
			end else if (t4_fire && load_pc) begin
				pc <= next_pc; // see [RQ8]
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ir <= DUMMY_INSTR;
			ext_second <= 1'b0;
			irq_ack_o <= 1'b0;
		end else begin
			irq_ack_o <= t4_fire && take_irq;
			if (t4_fire) begin
				ext_second <= ext_hold;
				if (ext_hold) begin
					ir <= ir;
				end else if (flush) begin
					ir <= DUMMY_INSTR; // see [RQ9] [RQ5]
				end else begin
					ir <= prog_data_i; // see [RQ3]
				end
			end
		end
	end

	// Overflow wraps the pointer; depth saturates so the oldest entry is lost
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sp <= 3'h0; // see [RQ15]
			depth <= STACK_EMPTY_DEPTH;
		end else if (t4_fire && push) begin
			sp <= sp + 3'h1;
			if (!stack_full) begin
				depth <= depth + 4'h1; // see [RQ17]
			end
		end else if (t4_fire && pop) begin
			sp <= sp - 3'h1;
			if (depth != STACK_EMPTY_DEPTH) begin
				depth <= depth - 4'h1;
			end
		end
	end

	return_stack_ram u_stack (
		.clock_i(clock_i),
		.wr_en_i(t4_fire && push),
		.wr_addr_i(sp),
		.wr_data_i(return_addr),
		.rd_addr_i(sp - 3'h1),
		.rd_data_o(stack_top)
	); // see [RQ12]

	always_comb begin
		logic [8:0] sum;
		sum = 9'h000;
		next_acc = acc;
		next_flags = flags;
		case (alu_op)
			ALU_ADD, ALU_ADC: begin
				sum = {1'b0, acc} + {1'b0, operand} + 9'((alu_op == ALU_ADC) & flags[FLAG_C]);
				next_flags[FLAG_C] = sum[8];
				next_flags[FLAG_AC] = (acc[3:0] + operand[3:0]) > 5'h0F;
				next_flags[FLAG_OV] = (acc[7] == operand[7]) && (sum[7] != acc[7]);
			end
			ALU_SUB, ALU_SBC: begin
				// Carry set means no borrow
				sum = {1'b0, acc} + {1'b0, ~operand}
					+ 9'((alu_op == ALU_SUB) | flags[FLAG_C]);
				next_flags[FLAG_C] = sum[8];
				next_flags[FLAG_AC] = acc[3:0] >= operand[3:0];
				next_flags[FLAG_OV] = (acc[7] != operand[7]) && (sum[7] != acc[7]);
			end
			ALU_DAA: begin
				sum = {1'b0, acc};
				if (acc[3:0] > 4'h9 || flags[FLAG_AC]) begin
					sum = sum + 9'h006;
				end
				if (sum[7:4] > 4'h9 || flags[FLAG_C] || sum[8]) begin
					sum = sum + 9'h060;
				end
				next_flags[FLAG_C] = sum[8] | flags[FLAG_C];
			end
			ALU_AND: sum = {1'b0, acc & operand};
			ALU_OR: sum = {1'b0, acc | operand};
			ALU_XOR: sum = {1'b0, acc ^ operand};
			ALU_CPL: sum = {1'b0, ~acc};
			ALU_RR: sum = {1'b0, acc[0], acc[7:1]};
			ALU_RL: sum = {1'b0, acc[6:0], acc[7]};
			ALU_RRC: begin
				sum = {1'b0, flags[FLAG_C], acc[7:1]};
				next_flags[FLAG_C] = acc[0];
			end
			ALU_RLC: begin
				sum = {1'b0, acc[6:0], flags[FLAG_C]};
				next_flags[FLAG_C] = acc[7];
			end
			ALU_INC: sum = {1'b0, acc + 8'h01};
			ALU_DEC: sum = {1'b0, acc - 8'h01};
			ALU_MOV: sum = {1'b0, operand};
			default: sum = {1'b0, acc};
		endcase
		next_acc = sum[7:0];
		// Rotates and MOV leave zero alone
		if (!(alu_op inside {ALU_RR, ALU_RL, ALU_RRC, ALU_RLC, ALU_MOV})) begin
			next_flags[FLAG_Z] = (sum[7:0] == 8'h00);
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc <= ACC_RESET;
			flags <= FLAGS_RESET;
		end else if (t4_fire && alu_en) begin
			acc <= next_acc; // see [RQ18] [RQ20]
			flags <= next_flags; // see [RQ19]
		end
	end

	// A software write that lands as the core takes the old one is kept
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pc_low_req <= 1'b0;
			pc_low_data <= 8'h00;
		end else if (apb_write && apb_i.paddr == OFF_PC_LOW) begin
			pc_low_req <= 1'b1; // see [RQ10]
			pc_low_data <= apb_i.pwdata[7:0];
		end else if (t4_fire && pc_low_taken) begin
			pc_low_req <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run <= CTRL_RUN_RESET;
		end else if (apb_write && apb_i.paddr == OFF_CTRL) begin
			run <= apb_i.pwdata[CTRL_RUN_BIT];
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			apb_o <= '0;
		end else begin
			apb_o.pready <= apb_setup;
			apb_o.pslverr <= 1'b0;
			apb_o.prdata <= 32'h00000000;
			if (apb_setup) begin
				case (apb_i.paddr)
					OFF_PC_LOW: apb_o.prdata <= {24'h000000, pc[7:0]}; // see [RQ10] [RQ7]
					OFF_CTRL: apb_o.prdata <= {31'h00000000, run};
					OFF_STATE: apb_o.prdata <= {12'h000, flags, 4'h0, pc};
					OFF_ACC: apb_o.prdata <= {24'h000000, acc};
					default: apb_o.pslverr <= 1'b1;
				endcase
			end
		end
	end

	a_phase_wrap: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see [RQ1]
		t4_fire |=> phase == PHASE_T1)
		else $error("phase did not wrap to T1");
	a_pc_increment: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see [RQ2]
		t1_fire |=> pc == $past(pc) + 12'h001 && prog_addr_o == $past(pc))
		else $error("fetch did not advance counter");
	a_branch_dummy: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see [RQ9]
		t4_fire && flush && !ext_hold |=> ir == DUMMY_INSTR)
		else $error("prefetch not discarded");
	a_ack_not_full: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see [RQ16]
		irq_ack_o |-> $past(depth) != STACK_FULL_DEPTH)
		else $error("acknowledge with full stack");
	a_pc_low_page: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see [RQ11]
		t4_fire && pc_low_taken |=> pc[11:8] == $past(pc[11:8]) && pc[7:0] == $past(pc_low_data))
		else $error("low byte jump left page");
	a_push_depth: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see [RQ17]
		t4_fire && push |=> depth == ($past(stack_full) ? STACK_FULL_DEPTH : $past(depth) + 4'h1))
		else $error("stack depth wrong after push");
	a_pop_restore: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see [RQ14]
		t4_fire && pop |=> pc == $past(stack_top) ##4 prog_addr_o == $past(stack_top, 5))
		else $error("return address not restored");
	a_ext_two: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see [RQ4]
		t4_fire && ext_hold |=> ext_second && !t4_fire ##3 t4_fire && alu_en)
		else $error("extended op not two cycles");
	a_apb_answer: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		apb_setup |=> apb_o.pready)
		else $error("no bus answer");

	c_call: cover property (@(posedge clock_i) disable iff (!rst_n_i) t4_fire && op_class == OP_CALL);
	c_irq: cover property (@(posedge clock_i) disable iff (!rst_n_i) irq_ack_o);
	c_full_wait: cover property (@(posedge clock_i) disable iff (!rst_n_i) irq_i && stack_full);
	c_skip: cover property (@(posedge clock_i) disable iff (!rst_n_i)
		t4_fire && op_class == OP_SKIP && flush);
endmodule
`default_nettype wire

// ---- test/prog_irq_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module prog_irq_model
	import pc_seq_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [PC_W-1:0] prog_addr_i,
	input wire logic prog_rd_i,
	output logic [INSTR_W-1:0] prog_data_o,
	input wire logic raise_i,
	input wire logic irq_ack_i,
	output logic irq_o
);
	logic [INSTR_W-1:0] rom [0:4095];
	logic [INSTR_W-1:0] last_word;
	logic [1:0] hold;

	initial begin
		for (int i = 0; i < 4096; i++) begin
			rom[i] = DUMMY_INSTR;
		end
	end

	// Word lasts one cycle past the sampling edge; junk after so a late sample shows
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hold <= 2'h0;
			last_word <= 16'h0000;
		end else if (prog_rd_i) begin
			hold <= 2'h3;
			last_word <= rom[prog_addr_i];
		end else if (hold != 2'h0) begin
			hold <= hold - 2'h1;
		end
	end

	assign prog_data_o = (prog_rd_i || hold != 2'h0) ? rom[prog_addr_i] : ~last_word;

	// Request level stays up until acknowledged
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_o <= 1'b0;
		end else if (raise_i) begin
			irq_o <= 1'b1;
		end else if (irq_ack_i) begin
			irq_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- test/cpu_fetch_pc_stack_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_total++; $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module cpu_fetch_pc_stack_tb
	import pc_seq_pkg::*;
;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	apb_req_t apb_req = '0;
	apb_rsp_t apb_rsp;
	logic [INSTR_W-1:0] prog_data;
	logic [PC_W-1:0] prog_addr;
	logic prog_rd;
	logic irq;
	logic irq_ack;
	logic raise = 1'b0;
	logic [PHASE_COUNT-1:0] phase;
	logic [PHASE_COUNT-1:0] prev_phase = '0;
	logic [4095:0] seen = '0;
	logic [PC_W-1:0] trace [$];
	int err_total = 0;
	int check_count = 0;
	int gap = 0;
	int acks = 0;
	logic [31:0] rdata;
	logic perr;
	// Skipped slot 022 and discarded slots 003, 011 and 013 change the accumulator if wrongly executed
	localparam logic [27:0] PROG [18] = '{28'h000_1F05, 28'h001_1003, 28'h002_3010,
		28'h003_1F99, 28'h010_4020, 28'h011_1038, 28'h012_8000, 28'h013_1F11,
		28'h020_7000, 28'h021_7100, 28'h022_1077, 28'h023_5000, 28'h040_1040,
		28'h041_2280, 28'h042_3042, 28'h059_3059, 28'h070_5000, 28'h004_6000};
	localparam logic [11:0] EXP [15] = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h010,
		12'h011, 12'h020, 12'h021, 12'h022, 12'h023, 12'h024, 12'h011, 12'h012,
		12'h013, 12'h040};

	always #5 clock_i = ~clock_i;

	cpu_fetch_pc_stack i_cpu_fetch_pc_stack (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .apb_i(apb_req), .apb_o(apb_rsp),
		.prog_data_i(prog_data), .prog_addr_o(prog_addr), .prog_rd_o(prog_rd),
		.irq_i(irq), .irq_ack_o(irq_ack), .instruction_phase_clocks_o(phase));

	prog_irq_model i_prog_irq_model (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .prog_addr_i(prog_addr),
		.prog_rd_i(prog_rd), .prog_data_o(prog_data), .raise_i(raise),
		.irq_ack_i(irq_ack), .irq_o(irq));

	always @(posedge clock_i) begin
		gap <= gap + 1;
		prev_phase <= phase;
		if (prog_rd === 1'b1) begin
			trace.push_back(prog_addr);
			seen[prog_addr] <= 1'b1;
			gap <= 1;
			if (trace.size() > 1) `CHK("fetch spacing", 0, gap % 4)
		end
		if (irq_ack === 1'b1) acks <= acks + 1;
		if (phase != '0 && prev_phase != '0) `CHK("phase order", {prev_phase[2:0], prev_phase[3]}, phase)
	end

	task automatic wrap_up();
		if (err_total == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic give_up();
		err_total++;
		$display("ERROR wait limit expected 0 seen 1");
		wrap_up();
	endtask

	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clock_i);
		apb_req.psel <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite <= wr;
		apb_req.paddr <= addr;
		apb_req.pwdata <= wd;
		@(posedge clock_i);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge clock_i);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 50);
		if (n >= 50) give_up();
		rdata = apb_rsp.prdata;
		perr = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask

	task automatic wait_fetch(input logic [PC_W-1:0] a);
		int n;
		n = 0;
		check_count++;
		while (seen[a] !== 1'b1) begin
			if (n++ > 600) give_up();
			@(posedge clock_i);
		end
	endtask

	initial begin
		repeat (2) @(posedge clock_i);
		foreach (PROG[k]) i_prog_irq_model.rom[PROG[k][27:16]] = PROG[k][15:0];
		for (int k = 0; k < 9; k++) i_prog_irq_model.rom[12'h050 + k] = 16'(16'h4051 + k);
		repeat (18) @(posedge clock_i);
		rst_n_i <= 1'b1;
		apb(1'b0, OFF_ACC, '0);
		`CHK("acc reset", 32'h0, rdata)
		apb(1'b0, OFF_CTRL, '0);
		`CHK("ctrl reset", 32'h1, rdata)
		apb(1'b0, 8'h10, 32'h0);
		`CHK("unmapped error", 1'b1, perr)
		`CHK("unmapped data", 32'h0, rdata)
		for (int n = 0; trace.size() < 15; n++) begin
			if (n > 500) give_up();
			@(posedge clock_i);
		end
		foreach (EXP[k]) `CHK("fetch order", EXP[k], trace[k])
		wait_fetch(12'h043);
		apb(1'b0, OFF_ACC, '0);
		`CHK("acc result", 32'h0, rdata)
		apb(1'b0, OFF_STATE, '0);
		`CHK("status flags", 32'h0005_0000, rdata & 32'h0005_0000)
		seen = '0;
		apb(1'b1, OFF_PC_LOW, 32'h50);
		wait_fetch(12'h059);
		apb(1'b0, OFF_PC_LOW, '0);
		`CHK("pc low page", 32'h50, rdata & 32'hFFFF_FFF0)
		@(posedge clock_i);
		raise <= 1'b1;
		@(posedge clock_i);
		raise <= 1'b0;
		repeat (60) @(posedge clock_i);
		`CHK("ack withheld", 0, acks)
		seen = '0;
		apb(1'b1, OFF_PC_LOW, 32'h70);
		wait_fetch(12'h004);
		`CHK("ack count", 1, acks)
		seen = '0;
		wait_fetch(12'h059);
		wrap_up();
	end
endmodule
`default_nettype wire
